//--- common/swd_pkg.sv
// constants shared by the switch detect serial command block
package swd_pkg;
    localparam int          WORD_BITS      = 24;
    localparam logic [5:0]  WORD_BITS_C    = 6'h18;
    localparam int          CFG_INPUTS     = 8;
    localparam int          GND_INPUTS     = 14;
    // command codes in bits 23..16
    localparam logic [7:0]  CMD_SETTINGS   = 8'h01;
    localparam logic [7:0]  CMD_WAKE_CFG   = 8'h02;
    localparam logic [7:0]  CMD_WAKE_GND   = 8'h03;
    // values after power-on reset
    localparam logic [7:0]  POLARITY_RST   = 8'hFF;
    localparam logic [7:0]  CFG_WAKE_RST   = 8'hFF;
    localparam logic [13:0] GND_WAKE_RST   = 14'h3FFF;
    // response word layout: bit 23 interrupt, bit 22 thermal, 21..0 status
    localparam int          RSP_INT_BIT    = 23;
    localparam int          RSP_THERM_BIT  = 22;
    localparam int          RSP_GND_LSB    = 0;
    localparam int          RSP_CFG_LSB    = 14;
    typedef enum logic [0:0] {
        SWD_NORMAL = 1'b0,
        SWD_SLEEP  = 1'b1
    } swd_mode_t;
endpackage

//--- hdl/swd_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module swd_sync #(
    parameter int W   = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_r <= INIT;
            sync_o <= INIT;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule

//--- hdl/swd_core.sv
// serial command interface and mode control of the switch detector
`timescale 1ns/1ps
module swd_core #(
    parameter int CFG_N = swd_pkg::CFG_INPUTS,
    parameter int GND_N = swd_pkg::GND_INPUTS
) (
    // clock and reset (reset is the battery power-on reset)
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    // serial link pins
    input  wire logic             sclk_i,
    input  wire logic             cs_n_i,
    input  wire logic             si_i,
    output logic                  so_o,
    output logic                  so_oe_o,
    // interrupt open-drain pin
    input  wire logic             int_n_i,
    output logic                  int_n_o,
    output logic                  int_n_oe_o,
    // wake open-drain pin
    input  wire logic             wake_n_i,
    output logic                  wake_n_o,
    output logic                  wake_n_oe_o,
    // comparator results, raw pin levels above threshold
    input  wire logic [CFG_N-1:0] configurable_inputs_i,
    input  wire logic [GND_N-1:0] ground_only_inputs_i,
    // other device inputs
    input  wire logic             iface_supply_ok_i,
    input  wire logic             thermal_flag_i,
    input  wire logic             int_timer_expired_i,
    input  wire logic             sleep_req_i,
    // settings and state seen by the analog side
    output logic [CFG_N-1:0]      input_sense_polarity_o,
    output logic [CFG_N-1:0]      cfg_wake_enable_o,
    output logic [GND_N-1:0]      gnd_wake_enable_o,
    output logic                  normal_mode_o
);
    localparam int W  = swd_pkg::WORD_BITS;
    localparam int NI = 5 + CFG_N + GND_N + 1;

    logic [NI-1:0]   raw_w;
    logic [NI-1:0]   syn_w;
    logic            sclk_s;
    logic            cs_n_s;
    logic            si_s;
    logic            intp_s;
    logic            wakep_s;
    logic            vdd_s;
    logic [CFG_N-1:0] cfg_s;
    logic [GND_N-1:0] gnd_s;

    assign raw_w = {sclk_i, cs_n_i, si_i, int_n_i, wake_n_i,
                    configurable_inputs_i, ground_only_inputs_i,
                    iface_supply_ok_i};

    // every outside input except thermal_flag_i, int_timer_expired_i and sleep_req_i passes two flops before it is read
    swd_sync #(
        .W    (NI),
        .INIT ({1'b0, 1'b1, 1'b0, 1'b1, 1'b1,
                {(CFG_N+GND_N){1'b0}}, 1'b0})
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (raw_w),
        .sync_o    (syn_w)
    );

    assign {sclk_s, cs_n_s, si_s, intp_s, wakep_s, cfg_s, gnd_s, vdd_s}
        = syn_w;

    // edge history of the synchronised pins
    logic sclk_d_r;
    logic cs_n_d_r;
    logic intp_d_r;
    logic wakep_d_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sclk_d_r  <= 1'b0;
            cs_n_d_r  <= 1'b1;
            intp_d_r  <= 1'b1;
            wakep_d_r <= 1'b1;
        end else begin
            sclk_d_r  <= sclk_s;
            cs_n_d_r  <= cs_n_s;
            intp_d_r  <= intp_s;
            wakep_d_r <= wakep_s;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic active;

    // without interface supply clock edges and select fall are dead; a select rise can still clear the interrupt flag
    assign active    = vdd_s && !cs_n_s;
    assign cs_fall   = vdd_s && cs_n_d_r && !cs_n_s;
    assign cs_rise   = !cs_n_d_r && cs_n_s;
    assign sclk_rise = active && !sclk_d_r && sclk_s;
    assign sclk_fall = active && sclk_d_r && !sclk_s;

    // closed-switch view: battery-sense inputs close when high
    logic [CFG_N-1:0] cfg_closed;
    logic [GND_N-1:0] gnd_closed;
    logic [CFG_N-1:0] pol_r;
    logic [CFG_N-1:0] cfg_en_r;
    logic [GND_N-1:0] gnd_en_r;

    assign cfg_closed = ~(cfg_s ^ pol_r);
    assign gnd_closed = ~gnd_s;

    logic [CFG_N-1:0] cfg_prev_r;
    logic [GND_N-1:0] gnd_prev_r;
    logic [2:0]       prev_ok_r;
    logic             change_en;
    logic             closure_en;

    // the sync flops show reset values for two cycles; comparing against
    // them would raise a false change, so history counts only after three
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cfg_prev_r <= '0;
            gnd_prev_r <= '0;
            prev_ok_r  <= 3'h0;
        end else begin
            cfg_prev_r <= cfg_s;
            gnd_prev_r <= gnd_s;
            prev_ok_r  <= {prev_ok_r[1:0], 1'b1};
        end
    end

    // raw levels are compared: a polarity rewrite is no switch change
    // only enabled inputs count as change or closure
    assign change_en = prev_ok_r[2] &&
        (|((cfg_s ^ cfg_prev_r) & cfg_en_r) ||
         |((gnd_s ^ gnd_prev_r) & gnd_en_r));
    assign closure_en = prev_ok_r[2] &&
        (|(cfg_closed & (cfg_prev_r ^ pol_r) & cfg_en_r) ||
         |(gnd_closed & gnd_prev_r & gnd_en_r));

    // operating mode
    swd_pkg::swd_mode_t mode_r;
    logic               wake_evt;

    assign wake_evt = change_en ||
                      (wakep_d_r && !wakep_s) ||
                      (vdd_s && wakep_s && intp_d_r && !intp_s) ||
                      cs_fall ||
                      int_timer_expired_i;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mode_r <= swd_pkg::SWD_NORMAL;
        end else begin
            case (mode_r)
                swd_pkg::SWD_NORMAL: begin
                    // losing the interface supply alone never sleeps
                    if (sleep_req_i && !wake_evt) begin
                        mode_r <= swd_pkg::SWD_SLEEP;
                    end
                end
                swd_pkg::SWD_SLEEP: begin
                    if (wake_evt) begin
                        mode_r <= swd_pkg::SWD_NORMAL;
                    end
                end
                default: mode_r <= swd_pkg::SWD_NORMAL;
            endcase
        end
    end

    assign normal_mode_o = (mode_r == swd_pkg::SWD_NORMAL);

    // interrupt flag; a closure while selected keeps it set
    logic int_r;
    logic closed_in_frame_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            closed_in_frame_r <= 1'b0;
        end else if (!cs_n_s && closure_en) begin
            // a closure in the select cycle itself still counts
            closed_in_frame_r <= 1'b1;
        end else if (cs_fall) begin
            closed_in_frame_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            int_r <= 1'b0;
        end else if (normal_mode_o && change_en) begin
            // set wins over a clear in the same cycle
            int_r <= 1'b1;
        end else if (cs_rise && !closed_in_frame_r) begin
            int_r <= 1'b0;
        end
    end

    assign int_n_o    = 1'b0;
    assign int_n_oe_o = int_r;
    assign wake_n_o   = 1'b0;
    assign wake_n_oe_o = normal_mode_o;

    // shift path
    logic [W-1:0] rx_r;
    logic [W-1:0] tx_r;
    logic [5:0]   cnt_r;
    logic         sel_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sel_r <= 1'b0;
        end else if (cs_fall) begin
            sel_r <= 1'b1;
        end else if (cs_rise || !vdd_s) begin
            sel_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
            rx_r  <= '0;
        end else if (cs_fall) begin
            cnt_r <= '0;
        end else if (sel_r && sclk_fall) begin
            rx_r  <= {rx_r[W-2:0], si_s};
            if (cnt_r != 6'h3F) begin
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_r <= '0;
        end else if (cs_fall) begin
            // snapshot of status and flags at select fall
            tx_r <= '0;
            tx_r[swd_pkg::RSP_INT_BIT]   <= int_r;
            tx_r[swd_pkg::RSP_THERM_BIT] <= thermal_flag_i;
            tx_r[swd_pkg::RSP_CFG_LSB +: CFG_N] <= cfg_closed;
            tx_r[swd_pkg::RSP_GND_LSB +: GND_N] <= gnd_closed;
        end else if (sel_r && sclk_rise && cnt_r != 6'h00) begin
            // bit 23 is shown at select fall, the next on each rise after the first
            tx_r <= {tx_r[W-2:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            so_o    <= tx_r[W-1];
            so_oe_o <= sel_r && !cs_rise;
        end
    end

    // command apply at select rise
    logic       apply;
    logic [7:0] code;

    assign code  = rx_r[W-1:W-8];
    // full 24 clocks only; supply and mode gate it
    assign apply = cs_rise && sel_r && vdd_s && normal_mode_o &&
                   cnt_r == swd_pkg::WORD_BITS_C;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pol_r <= swd_pkg::POLARITY_RST;
        end else if (apply && code == swd_pkg::CMD_SETTINGS) begin
            pol_r <= rx_r[CFG_N-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cfg_en_r <= swd_pkg::CFG_WAKE_RST;
        end else if (apply && code == swd_pkg::CMD_WAKE_CFG) begin
            cfg_en_r <= rx_r[CFG_N-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            gnd_en_r <= swd_pkg::GND_WAKE_RST;
        end else if (apply && code == swd_pkg::CMD_WAKE_GND) begin
            gnd_en_r <= rx_r[GND_N-1:0];
        end
        // any other code leaves every register alone
    end

    assign input_sense_polarity_o = pol_r;
    assign cfg_wake_enable_o      = cfg_en_r;
    assign gnd_wake_enable_o      = gnd_en_r;
endmodule

//--- verif/swd_core_monitor.sv
// port assertions for the switch detect serial block
`timescale 1ns/1ps
module swd_core_monitor #(
    parameter int CFG_N = 8,
    parameter int GND_N = 14
) (
    input wire logic             sys_clk_i,
    input wire logic             sys_rst_i,
    input wire logic             cs_n_i,
    input wire logic             so_oe_o,
    input wire logic             int_n_oe_o,
    input wire logic             wake_n_oe_o,
    input wire logic [CFG_N-1:0] configurable_inputs_i,
    input wire logic [GND_N-1:0] ground_only_inputs_i,
    input wire logic             iface_supply_ok_i,
    input wire logic             sleep_req_i,
    input wire logic [CFG_N-1:0] input_sense_polarity_o,
    input wire logic [CFG_N-1:0] cfg_wake_enable_o,
    input wire logic [GND_N-1:0] gnd_wake_enable_o,
    input wire logic             normal_mode_o
);
    wire logic [2*CFG_N+GND_N-1:0] regs = {input_sense_polarity_o,
        cfg_wake_enable_o, gnd_wake_enable_o};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_reset_defaults: assert property ($fell(sys_rst_i) |->
        normal_mode_o && wake_n_oe_o && &regs) else $error("reset value");
    a_idle_no_so: assert property (cs_n_i[*8] |-> !so_oe_o)
        else $error("so driven while idle");
    a_so_on_select: assert property ($fell(cs_n_i) && iface_supply_ok_i
        && normal_mode_o |-> ##[2:8] so_oe_o) else $error("so not driven");
    a_regs_idle: assert property (cs_n_i[*8] |=> $stable(regs))
        else $error("register moved while idle");
    a_no_vdd_prog: assert property (!iface_supply_ok_i[*8]
        |=> $stable(regs)) else $error("programmed without supply");
    a_sleep_no_prog: assert property (!normal_mode_o[*8]
        |=> $stable(regs)) else $error("programmed in sleep");
    a_wake_low_normal: assert property (normal_mode_o[*3]
        |-> wake_n_oe_o) else $error("wake pin not low");
    a_wake_free_sleep: assert property (!normal_mode_o[*3]
        |-> !wake_n_oe_o) else $error("wake pin not released");
    a_normal_kept: assert property ((!sleep_req_i)[*6] ##0
        normal_mode_o |=> normal_mode_o) else $error("left normal");
    a_int_needs_change: assert property (($stable(configurable_inputs_i)
        && $stable(ground_only_inputs_i))[*8] |=> !$rose(int_n_oe_o))
        else $error("interrupt without change");
endmodule

bind swd_core swd_core_monitor #(.CFG_N(CFG_N), .GND_N(GND_N))
    i_swd_core_monitor (.sys_clk_i, .sys_rst_i, .cs_n_i, .so_oe_o,
    .int_n_oe_o, .wake_n_oe_o, .configurable_inputs_i,
    .ground_only_inputs_i, .iface_supply_ok_i, .sleep_req_i,
    .input_sense_polarity_o, .cfg_wake_enable_o, .gnd_wake_enable_o,
    .normal_mode_o);

//--- verif/swd_spi_master.sv
// serial controller model framing exchanges with the device
`timescale 1ns/1ps
module swd_spi_master (
    input  wire logic sys_clk_i,
    input  wire logic so_o,
    input  wire logic so_oe_o,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o
);
    // a released line shows the inverse so a stale bit never matches
    wire logic so_line = so_oe_o ? so_o : ~so_o;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // n clocks with select low, 24 is a whole word
    task automatic xfer(input logic [23:0] cmd, input int n,
                        output logic [23:0] rsp);
        rsp = '0;
        cyc(1);
        cs_n_o <= 1'b0;
        cyc(8);
        for (int k = 0; k < n; k++) begin
            sclk_o <= 1'b1;
            si_o <= cmd[23-k];
            cyc(4);
            sclk_o <= 1'b0;
            cyc(4);
            // read late in the low phase: the device path is synchronised
            rsp = {rsp[22:0], so_line};
        end
        cyc(4);
        cs_n_o <= 1'b1; // select moves only with the clock low
        cyc(16);
    endtask
endmodule

//--- verif/swd_core_test.sv
// self-checking bench for the switch detect serial block
`timescale 1ns/1ps
module swd_core_test;
    logic        sys_clk_i, sys_rst_i, iface_supply_ok_i, thermal_flag_i;
    logic        int_timer_expired_i, sleep_req_i, ext_wake, ext_int;
    logic [7:0]  configurable_inputs_i, input_sense_polarity_o;
    logic [7:0]  cfg_wake_enable_o;
    logic [13:0] ground_only_inputs_i, gnd_wake_enable_o;
    logic        sclk_i, cs_n_i, si_i, so_o, so_oe_o, int_n_oe_o;
    logic        wake_n_oe_o, normal_mode_o;
    logic [23:0] rsp;
    int          n_mismatch, checked;
    wire logic   int_n_i = ~(int_n_oe_o | ext_int);
    wire logic   wake_n_i = ~(wake_n_oe_o | ext_wake);
    logic [7:0]  bad [3] = '{8'h00, 8'h04, 8'hFF};

    swd_core i_swd_core (.sys_clk_i, .sys_rst_i, .sclk_i, .cs_n_i,
        .si_i, .so_o, .so_oe_o, .int_n_i, .int_n_o(), .int_n_oe_o,
        .wake_n_i, .wake_n_o(), .wake_n_oe_o, .configurable_inputs_i,
        .ground_only_inputs_i, .iface_supply_ok_i, .thermal_flag_i,
        .int_timer_expired_i, .sleep_req_i, .input_sense_polarity_o,
        .cfg_wake_enable_o, .gnd_wake_enable_o, .normal_mode_o);
    swd_spi_master i_swd_spi_master (.sys_clk_i, .so_o, .so_oe_o,
        .sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_int(input logic e);
        int i;
        for (i = 0; i < 100 && int_n_oe_o !== e; i++) cyc(1);
        chk(int_n_oe_o, e);
        if (i == 100) tally_and_finish();
    endtask
    task automatic nap;
        sleep_req_i <= 1'b1;
        cyc(8);
        sleep_req_i <= 1'b0;
        cyc(8);
    endtask
    task automatic xfer(input logic [23:0] c);
        i_swd_spi_master.xfer(c, 24, rsp);
    endtask

    initial begin
        sys_rst_i = 1'b1;
        iface_supply_ok_i = 1'b1;
        thermal_flag_i = 1'b1;
        int_timer_expired_i = 1'b0;
        sleep_req_i = 1'b0;
        ext_wake = 1'b0;
        ext_int = 1'b0;
        configurable_inputs_i = 8'hF0;
        ground_only_inputs_i = 14'h3FFE;
        n_mismatch = 0;
        checked = 0;
        cyc(20);
        sys_rst_i <= 1'b0;
        cyc(6);
        chk({normal_mode_o, wake_n_oe_o, so_oe_o, int_n_oe_o}, 4'hC);
        chk({input_sense_polarity_o, cfg_wake_enable_o, gnd_wake_enable_o},
            30'h3FFFFFFF);
        // bits 15..8 carry junk that must be dropped
        xfer({swd_pkg::CMD_SETTINGS, 16'hFF5A});
        chk(rsp, {2'b01, 8'hF0, 14'h0001});
        chk(input_sense_polarity_o, 8'h5A);
        foreach (bad[i]) begin
            xfer({bad[i], 16'hFFFF});
            chk(rsp, {2'b01, 8'h55, 14'h0001});
            chk(input_sense_polarity_o, 8'h5A);
        end
        i_swd_spi_master.xfer({swd_pkg::CMD_SETTINGS, 16'h0000}, 23, rsp);
        chk(input_sense_polarity_o, 8'h5A);
        xfer({swd_pkg::CMD_WAKE_CFG, 16'h00FE});
        xfer({swd_pkg::CMD_WAKE_GND, 16'hC001});
        chk({cfg_wake_enable_o, gnd_wake_enable_o}, {8'hFE, 14'h0001});
        ground_only_inputs_i[0] <= 1'b1;
        wait_int(1'b1);
        xfer(24'h000000);
        chk(rsp[23], 1'b1);
        wait_int(1'b0);
        fork
            xfer(24'h000000);
            begin
                cyc(100);
                ground_only_inputs_i[0] <= 1'b0;
            end
        join
        chk(int_n_oe_o, 1'b1);
        xfer(24'h000000);
        wait_int(1'b0);
        ground_only_inputs_i[1] <= 1'b0;
        configurable_inputs_i[0] <= 1'b1;
        cyc(30);
        chk(int_n_oe_o, 1'b0);
        nap();
        chk({normal_mode_o, wake_n_oe_o}, 2'b00);
        iface_supply_ok_i <= 1'b0;
        cyc(8);
        xfer({swd_pkg::CMD_SETTINGS, 16'h0000});
        chk({normal_mode_o, input_sense_polarity_o}, 9'h05A);
        ext_wake <= 1'b1;
        cyc(8);
        ext_wake <= 1'b0;
        cyc(30);
        chk(normal_mode_o, 1'b1);
        iface_supply_ok_i <= 1'b1;
        nap();
        int_timer_expired_i <= 1'b1;
        cyc(4);
        int_timer_expired_i <= 1'b0;
        cyc(8);
        chk(normal_mode_o, 1'b1);
        nap();
        ext_int <= 1'b1;
        cyc(4);
        ext_int <= 1'b0;
        cyc(8);
        chk(normal_mode_o, 1'b1);
        iface_supply_ok_i <= 1'b0;
        cyc(8);
        chk(normal_mode_o, 1'b1);
        nap();
        // interrupt pin edge without supply, then a disabled input change
        ext_int <= 1'b1;
        cyc(4);
        ext_int <= 1'b0;
        ground_only_inputs_i[1] <= 1'b1;
        cyc(12);
        chk(normal_mode_o, 1'b0);
        ground_only_inputs_i[0] <= 1'b1;
        cyc(12);
        chk(normal_mode_o, 1'b1);
        iface_supply_ok_i <= 1'b1;
        cyc(8);
        nap();
        xfer(24'h000000);
        chk(normal_mode_o, 1'b1);
        tally_and_finish();
    end
endmodule
